// File: hw/fecsl_defs.vh
// Constants for the flash correction status logger.
`ifndef FECSL_DEFS_VH
`define FECSL_DEFS_VH
`define FECSL_OP_CLEAR_CORR   8'h1b
`define FECSL_REG_STATUS      2'h0
`define FECSL_REG_TRAP        2'h1
`define FECSL_REG_COUNT       2'h2
`define FECSL_STATUS_DOUBLE   4
`define FECSL_STATUS_SINGLE   3
`define FECSL_STATUS_RESET    8'h00
`define FECSL_TRAP_RESET      32'h0000_0000
`define FECSL_COUNT_RESET     32'h0000_0000
`define FECSL_COUNT_MAX       32'hffff_ffff
`endif

// File: hw/fecsl_counter.v
// Saturating correction event counter.
`timescale 1ns/1ps
`default_nettype none
`include "fecsl_defs.vh"
module fecsl_counter (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        clear,
  input  wire        event_hit,
  output reg  [31:0] count
);
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= `FECSL_COUNT_RESET;
    else if (clear)
      count <= `FECSL_COUNT_RESET;
    else if (event_hit && count != `FECSL_COUNT_MAX)
      count <= count + 32'h0000_0001;
  end
endmodule // fecsl_counter
`default_nettype wire

// File: hw/fecsl_logger.v
// Correction status record, address trap and counter for the read path.
// Overview of operation
// - Each array read updates the record with the addressed unit's outcome.
// - The record accumulates every event since the last clear.
// - Host reads the record with the read-any-register command.
// - Record clears on power-on, hardware, software reset and clear command.
// - Bit 4 is a sticky double-bit flag, read only.
// - Bit 3 is a sticky single-bit flag, read only.
// - Bits 7:5 and 2:0 always read zero.
// - A double-bit event loads the error address trap.
// - Single-bit events load the trap only when selected.
// - Trap keeps only the first qualifying address until cleared.
// - Trap is four bytes and readable by the read-any-register command.
// - Trap clears on power-on, hardware reset and clear command only.
// - Counter increments on each correction, readable by host.
// - Counter counts single-bit and double-bit events alike.
// - Counter clears on clear command, power-on, hardware, software reset.
// - Clear command is instruction code 1Bh.
// - Trap holds the unit's byte address in bits 31:0, default zero.
`timescale 1ns/1ps
`default_nettype none
`include "fecsl_defs.vh"
module fecsl_logger (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        soft_reset,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_opcode,
  input  wire        read_done,
  input  wire [31:0] read_addr,
  input  wire        single_bit_err,
  input  wire        double_bit_err,
  input  wire        error_trap_select,
  input  wire        read_any_register_cmd,
  input  wire [1:0]  reg_index,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  output wire [7:0]  ecc_event_status,
  output wire [31:0] error_address_trap,
  output wire [31:0] correction_event_counter
);
  reg         double_bit_flag;
  reg         single_bit_flag;
  reg  [31:0] trap_addr;
  reg         trap_full;
  wire        clear_correction_cmd;
  wire        clr_record;
  wire        dbl_hit;
  wire        sgl_hit;
  wire        trap_hit;
  reg  [31:0] next_rdata;

  assign clear_correction_cmd = cmd_valid &&
                                (cmd_opcode == `FECSL_OP_CLEAR_CORR);
  assign clr_record = clear_correction_cmd || soft_reset;
  assign dbl_hit = read_done && double_bit_err;
  assign sgl_hit = read_done && single_bit_err;
  assign trap_hit = dbl_hit || (sgl_hit && error_trap_select);

  // sticky flags; a clear wins only when no event arrives.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      double_bit_flag <= 1'b0;
      single_bit_flag <= 1'b0;
    end
    else
    begin
      double_bit_flag <= dbl_hit | (double_bit_flag & ~clr_record);
      single_bit_flag <= sgl_hit | (single_bit_flag & ~clr_record);
    end
  end

  assign ecc_event_status = {3'h0, double_bit_flag, single_bit_flag,
                             3'h0};

  // first address trap; software reset leaves it alone.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trap_addr <= `FECSL_TRAP_RESET;
      trap_full <= 1'b0;
    end
    else if (trap_hit && (!trap_full || clear_correction_cmd))
    begin
      trap_addr <= read_addr;
      trap_full <= 1'b1;
    end
    else if (clear_correction_cmd)
    begin
      trap_addr <= `FECSL_TRAP_RESET;
      trap_full <= 1'b0;
    end
  end
  assign error_address_trap = trap_addr;

  // counter; an event in the clearing cycle is dropped.
  fecsl_counter u_counter (
    .clk       (clk),
    .rst_b     (rst_b),
    .clear     (clr_record),
    .event_hit (dbl_hit || sgl_hit),
    .count     (correction_event_counter)
  );

  always @*
  begin
    case (reg_index)
      `FECSL_REG_STATUS: next_rdata = {24'h000000, ecc_event_status};
      `FECSL_REG_TRAP:   next_rdata = trap_addr;
      `FECSL_REG_COUNT:  next_rdata = correction_event_counter;
      default:           next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= read_any_register_cmd;
      if (read_any_register_cmd)
        reg_rdata <= next_rdata;
    end
  end
endmodule // fecsl_logger
`default_nettype wire

// File: test/fecsl_sva.sv
// Checker for the correction status logger ports.
`timescale 1ns/1ps
`default_nettype none
module fecsl_sva (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        soft_reset,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_opcode,
  input wire logic        read_done,
  input wire logic [31:0] read_addr,
  input wire logic        single_bit_err,
  input wire logic        double_bit_err,
  input wire logic [7:0]  ecc_event_status,
  input wire logic [31:0] error_address_trap,
  input wire logic [31:0] correction_event_counter
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire        clr = cmd_valid && cmd_opcode == 8'h1b;
  wire        dbl = read_done && double_bit_err;
  wire        sgl = read_done && single_bit_err;
  wire [7:0]  st  = ecc_event_status;
  wire [31:0] tr  = error_address_trap;
  wire [31:0] ct  = correction_event_counter;
  flag_dbl_a: assert property (dbl |=> st[4]) else $error("double flag");
  flag_sgl_a: assert property (sgl |=> st[3]) else $error("single flag");
  rsvd_zero_a: assert property ((st & 8'he7) == 0) else $error("rsvd");
  trap_load_a: assert property (dbl && tr == 0 && ct == 0 |=>
    tr == $past(read_addr)) else $error("trap load");
  trap_keep_a: assert property (tr != 0 && !clr |=> $stable(tr))
    else $error("trap changed");
  clr_all_a: assert property (clr && !read_done |=>
    st == 0 && tr == 0 && ct == 0) else $error("clear");
  soft_clr_a: assert property (soft_reset && !read_done && !clr |=>
    st == 0 && ct == 0 && $stable(tr)) else $error("soft reset");
  cnt_inc_a: assert property ((sgl || dbl) && !soft_reset && !clr &&
    ~ct != 0 |=> ct == $past(ct) + 1) else $error("count");
  sat_hold_a: assert property (ct == 32'hffff_ffff && !clr &&
    !soft_reset |=> ct == 32'hffff_ffff) else $error("saturate");
  cover property (clr && tr != 0);
  cover property (sgl && !double_bit_err && tr == 0);
  cover property (soft_reset && tr != 0);
  cover property (sgl && !double_bit_err);
endmodule // fecsl_sva
bind fecsl_logger fecsl_sva u_sva (.*);
`default_nettype wire

// File: test/fecsl_host.sv
// Host model that fetches the logger registers.
`timescale 1ns/1ps
`default_nettype none
module fecsl_host (
  input  wire logic        clk,
  input  wire logic        reg_rvalid,
  input  wire logic [31:0] reg_rdata,
  output var  logic        read_any_register_cmd = 1'b0,
  output var  logic [1:0]  reg_index = 2'h0
);
  task rd(input logic [1:0] i, output logic [31:0] d, output logic ok);
    @(negedge clk) {read_any_register_cmd, reg_index} = {1'b1, i};
    @(negedge clk) {read_any_register_cmd, reg_index} = {1'b0, ~i};
    // The answer pulse lasts one cycle, so a late look would miss it.
    for (int k = 0; k < 3 && reg_rvalid !== 1'b1; k++) @(negedge clk);
    {ok, d} = {reg_rvalid === 1'b1, reg_rdata};
  endtask
endmodule // fecsl_host
`default_nettype wire

// File: test/flash_ecc_status_logger_tb.sv
// Self-checking bench for the correction status logger.
`timescale 1ns/1ps
`default_nettype none
module flash_ecc_status_logger_tb;
  logic clk = 0, rst_b = 0, soft_reset = 0, read_done = 0, ok, f = 0;
  logic single_bit_err = 0, double_bit_err = 0, error_trap_select = 0;
  logic read_any_register_cmd, cmd_valid = 0, reg_rvalid, bad;
  logic [1:0] reg_index;
  logic [7:0] cmd_opcode = 0, ecc_event_status, s = 0;
  logic [31:0] read_addr = 0, r = 32'h0001_800d, reg_rdata, d, a = 0, c = 0;
  logic [31:0] error_address_trap, correction_event_counter, e [4];
  int errors = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  fecsl_logger dut (.*);
  fecsl_host host (.*);
  function logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task wrap_up;
    $display("%0d compared, %0d failed", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task regs;
    e = '{{24'h0, s}, a, c, 0};
    foreach (e[i])
    begin
      host.rd(i[1:0], d, ok);
      bad = ok !== 1'b1 || d !== e[i];
      comparisons++;
      errors += bad;
      if (bad) $display("CHECK FAILED %0t reg %0d got %h", $time, i, d);
      if (!ok) wrap_up;
    end
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1;
    regs;
    repeat (300)
    begin
      r = nx(r);
      @(negedge clk);
      {read_done, single_bit_err, double_bit_err, error_trap_select} = r[3:0];
      {read_addr, soft_reset} = {r, r[7:4] == 4'h0};
      {s, c} = soft_reset ? 0 : {s, c + (r[3] && r[2:1] != 0)};
      s = s | {r[3] & r[1], r[3] & r[2], 3'h0};
      if (r[3] && !f && (r[1] || r[2] && r[0])) {f, a} = {1'b1, r};
      if (r[10:8] == 0)
      begin
        @(negedge clk);
        {read_done, soft_reset, cmd_valid, cmd_opcode} = {3'h1, 7'h0d, r[11]};
        @(negedge clk);
        {cmd_valid, cmd_opcode} = {1'b0, ~cmd_opcode};
        if (r[11]) {s, a, c, f} = 0;
        regs;
      end
    end
    $display("random reads and clears done");
    wrap_up;
  end
endmodule // flash_ecc_status_logger_tb
`default_nettype wire
